// >>> inc/drtb_pkg.sv
package drtb_pkg;
    // ------------------------------------------------------------
    // clocking and oscillator
    // ------------------------------------------------------------
    localparam int DRTB_CLK_HZ       = 32'h05F5_E100;  // 100 MHz system clock
    localparam int DRTB_OSC_TYP_HZ   = 32'h0000_DEA8;  // typical internal oscillator, 57 kHz
    localparam int DRTB_OSC_DIV      = DRTB_CLK_HZ / DRTB_OSC_TYP_HZ;
    // ------------------------------------------------------------
    // timebase ratios, in oscillator ticks
    // ------------------------------------------------------------
    localparam int DRTB_NUM_CHARS    = 32'h0000_0008;
    localparam int DRTB_REFRESH_DIV  = 32'h0000_00E0;  // 224 ticks per full refresh
    localparam int DRTB_CHAR_SLOT    = DRTB_REFRESH_DIV / DRTB_NUM_CHARS;
    localparam int DRTB_FLASH_DIV    = 32'h0000_7000;  // 28,672 ticks per blink period
    localparam int DRTB_SELFTEST_LEN = 32'h0004_0000;  // 262,144 ticks per self-test
    localparam int DRTB_LOCKOUT_TICKS = 32'h0000_0003; // ticks before host access is legal
    // ------------------------------------------------------------
    // host bus widths and self-test states
    // ------------------------------------------------------------
    localparam int DRTB_ADDR_W       = 32'h0000_0005;
    localparam int DRTB_DATA_W       = 32'h0000_0008;
    typedef enum logic [1:0] {
        DRTB_ST_IDLE = 2'b01,
        DRTB_ST_RUN  = 2'b10
    } drtb_selftest_t;
endpackage

// >>> inc/drtb_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// tick stream into a divider and its terminal-count pulse back
interface drtb_tick_if;
    logic tick;
    logic wrap;
    modport source (output tick, input wrap);
    modport counter(input tick, output wrap);
endinterface
`default_nettype wire

// >>> rtl/drtb_divider.sv
`timescale 1ns/1ps
`default_nettype none
module drtb_divider #(
    parameter int MOD = 2
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    drtb_tick_if.counter     tk
);
    localparam int CW = (MOD > 1) ? $clog2(MOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(MOD - 1);

    logic [CW-1:0] count_r;

    // ------------------------------------------------------------
    // modulo counter, advances only on a qualified tick
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (clkEn && tk.tick) begin
            count_r <= (count_r == LAST) ? '0 : count_r + 1'b1;
        end
    end

    assign tk.wrap = clkEn && tk.tick && (count_r == LAST);

    a_wrap_needs_tick: assert property (@(posedge clk) disable iff (!reset_n)
        tk.wrap |-> tk.tick && count_r == LAST ##1 count_r == '0)
        else $error("divider wrapped off its terminal count");
endmodule
`default_nettype wire

// >>> rtl/drtb_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module drtb_timebase
    import drtb_pkg::*;
#(
    parameter int OSC_DIV      = DRTB_OSC_DIV,
    parameter int FLASH_DIV    = DRTB_FLASH_DIV,
    parameter int SELFTEST_LEN = DRTB_SELFTEST_LEN
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   clkEn,
    input  wire logic                   clockSourceSelect,
    input  wire logic                   clkPinIn,
    output logic                        clkPinOut,
    output logic                        clkPinOe,
    input  wire logic                   ce_n,
    input  wire logic                   wr_n,
    input  wire logic                   rd_n,
    input  wire logic                   blinkMemorySelect_n,
    input  wire logic [DRTB_ADDR_W-1:0] addr,
    input  wire logic [DRTB_DATA_W-1:0] dataIn,
    input  wire logic                   selftestStart,
    output logic                        oscTick,
    output logic [2:0]                  charIndex_r,
    output logic                        refreshFrequency,
    output logic                        blinkPhase_r,
    output logic                        blinkFrequency,
    output logic                        selftestBusy,
    output logic                        selftestDone,
    output logic                        hostReady_r,
    output logic                        readActive,
    output logic                        writeDone,
    output logic [DRTB_ADDR_W-1:0]      wrAddr_r,
    output logic [DRTB_DATA_W-1:0]      wrData_r,
    output logic                        wrBlinkMem_r,
    output logic                        addrUnstable_r
);
    localparam int OCW = $clog2(OSC_DIV);
    localparam logic [OCW-1:0] OSC_HALF = OCW'(OSC_DIV / 2 - 1);
    localparam logic [2:0]     LAST_CHAR = 3'(DRTB_NUM_CHARS - 1);
    localparam logic [1:0]     LOCK_LAST = 2'(DRTB_LOCKOUT_TICKS);

    // ------------------------------------------------------------
    // oscillator source
    // ------------------------------------------------------------
    logic [OCW-1:0] oscCnt_r;
    logic           oscPhase_r;
    logic           pinPrev_r;
    logic           intTick;
    logic           extTick;

    // internal oscillator as a square wave, rising edge is the tick
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oscCnt_r   <= '0;
            oscPhase_r <= 1'b0;
        end else if (clkEn) begin
            if (oscCnt_r == OSC_HALF) begin
                oscCnt_r   <= '0;
                oscPhase_r <= !oscPhase_r;
            end else begin
                oscCnt_r <= oscCnt_r + 1'b1;
            end
        end
    end

    // pin level is synchronous already; history only for edge finding
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinPrev_r <= 1'b0;
        end else if (clkEn) begin
            pinPrev_r <= clkPinIn;
        end
    end

    assign intTick   = (oscCnt_r == OSC_HALF) && !oscPhase_r;
    assign extTick   = clkPinIn && !pinPrev_r;
    assign oscTick   = clkEn && (clockSourceSelect ? intTick : extTick);
    assign clkPinOut = oscPhase_r;
    assign clkPinOe  = clockSourceSelect;

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    drtb_tick_if slotIf ();
    drtb_tick_if flashIf ();
    drtb_tick_if testIf ();
    drtb_selftest_t testState_r;

    assign slotIf.tick  = oscTick;
    assign flashIf.tick = oscTick;
    assign testIf.tick  = oscTick && (testState_r == DRTB_ST_RUN);

    // one character slot per 28 ticks, eight slots make a refresh
    drtb_divider #(.MOD(DRTB_CHAR_SLOT)) uSlot (
        .clk     (clk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .tk      (slotIf.counter)
    );
    // half period per divider wrap so the full blink cycle is the ratio
    drtb_divider #(.MOD(FLASH_DIV / 2)) uFlash (
        .clk     (clk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .tk      (flashIf.counter)
    );
    // counter restarts at zero because it only ever stops on a wrap
    drtb_divider #(.MOD(SELFTEST_LEN)) uTest (
        .clk     (clk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .tk      (testIf.counter)
    );

    // ------------------------------------------------------------
    // refresh scan and blink phase
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            charIndex_r <= '0;
        end else if (slotIf.wrap) begin
            charIndex_r <= charIndex_r + 1'b1;
        end
    end

    assign refreshFrequency = slotIf.wrap && (charIndex_r == LAST_CHAR);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            blinkPhase_r <= 1'b0;
        end else if (flashIf.wrap) begin
            blinkPhase_r <= !blinkPhase_r;
        end
    end

    assign blinkFrequency = flashIf.wrap && blinkPhase_r;

    // ------------------------------------------------------------
    // self-test sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            testState_r <= DRTB_ST_IDLE;
        end else if (clkEn) begin
            case (testState_r)
                DRTB_ST_IDLE: begin
                    if (selftestStart) begin
                        testState_r <= DRTB_ST_RUN;
                    end
                end
                DRTB_ST_RUN: begin
                    if (testIf.wrap) begin
                        testState_r <= DRTB_ST_IDLE;
                    end
                end
                default: testState_r <= DRTB_ST_IDLE;
            endcase
        end
    end

    assign selftestBusy = (testState_r == DRTB_ST_RUN);
    assign selftestDone = testIf.wrap;

    // ------------------------------------------------------------
    // post-reset lockout
    // ------------------------------------------------------------
    logic [1:0] lockCnt_r;

    // counts oscillator ticks after release; before it readActive and writeDone are held low, though writes still load wrAddr_r and wrData_r
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lockCnt_r   <= '0;
            hostReady_r <= 1'b0;
        end else if (oscTick && !hostReady_r) begin
            lockCnt_r   <= lockCnt_r + 1'b1;
            hostReady_r <= (lockCnt_r + 1'b1 == LOCK_LAST);
        end
    end

    // ------------------------------------------------------------
    // host strobes
    // ------------------------------------------------------------
    logic writeLow;
    logic writeLow_r;
    logic ceLow_r;
    logic [DRTB_ADDR_W-1:0] ceAddr_r;

    // a tied write and chip enable look the same as a separate pair
    assign writeLow   = !ce_n && !wr_n;
    assign readActive = hostReady_r && !ce_n && !rd_n && wr_n;
    assign writeDone  = clkEn && writeLow_r && !writeLow && hostReady_r;

    // data keeps the last value seen while the strobe is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            writeLow_r   <= 1'b0;
            ceLow_r      <= 1'b0;
            ceAddr_r     <= '0;
            wrAddr_r     <= '0;
            wrData_r     <= '0;
            wrBlinkMem_r <= 1'b0;
        end else if (clkEn) begin
            writeLow_r <= writeLow;
            ceLow_r    <= !ce_n;
            if (!ce_n && !ceLow_r) begin
                ceAddr_r <= addr;
            end
            if (writeLow) begin
                wrAddr_r     <= addr;
                wrData_r     <= dataIn;
                wrBlinkMem_r <= !blinkMemorySelect_n;
            end
        end
    end

    // sticky warning: address moved under chip enable; only reset clears it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addrUnstable_r <= 1'b0;
        end else if (clkEn && ceLow_r && !ce_n && addr != ceAddr_r) begin
            addrUnstable_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [8:0]  refTicks_r;
    logic [31:0] testTicks_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            refTicks_r  <= '0;
            testTicks_r <= '0;
        end else if (oscTick) begin
            refTicks_r  <= refreshFrequency ? '0 : refTicks_r + 1'b1;
            testTicks_r <= (!selftestBusy || selftestDone) ? '0 : testTicks_r + 1'b1;
        end
    end

    a_refresh_period: assert property (@(posedge clk) disable iff (!reset_n)
        refreshFrequency |-> refTicks_r == 9'(DRTB_REFRESH_DIV - 1))
        else $error("refresh period is not 224 ticks");
    a_blink_on_tick: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(blinkPhase_r) |-> $past(oscTick))
        else $error("blink phase moved without an oscillator tick");
    a_selftest_length: assert property (@(posedge clk) disable iff (!reset_n)
        selftestDone |-> testTicks_r == 32'(SELFTEST_LEN - 1) ##1 !selftestBusy)
        else $error("self-test length wrong");
    a_lockout_release: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(hostReady_r) |-> $past(oscTick) && $past(lockCnt_r) == 2'(DRTB_LOCKOUT_TICKS - 1))
        else $error("lockout ended on wrong tick");
    a_write_gated: assert property (@(posedge clk) disable iff (!reset_n)
        writeDone |-> hostReady_r ##1 !writeLow_r && !writeDone)
        else $error("write completion without a full strobe");
    a_addr_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        addrUnstable_r |=> addrUnstable_r)
        else $error("address warning cleared");
    a_pin_source: assert property (@(posedge clk) disable iff (!reset_n)
        oscTick && !clockSourceSelect |-> clkPinIn && $past(clkPinIn) == 1'b0)
        else $error("external tick without a pin rising edge");
    a_freeze_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !clkEn |=> $stable(charIndex_r) && $stable(blinkPhase_r))
        else $error("state moved while clock enable low");

    c_refresh: cover property (@(posedge clk) disable iff (!reset_n) refreshFrequency);
    c_selftest: cover property (@(posedge clk) disable iff (!reset_n) selftestDone);
    c_write: cover property (@(posedge clk) disable iff (!reset_n) writeDone);
    c_ext_clock: cover property (@(posedge clk) disable iff (!reset_n) oscTick && !clockSourceSelect);
endmodule
`default_nettype wire

// >>> verification/drtb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host processor on the parallel bus
// ------------------------------------------------------------
module drtb_host_model
    import drtb_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   hostReady_r,
    output logic                        ce_n,
    output logic                        wr_n,
    output logic                        rd_n,
    output logic [DRTB_ADDR_W-1:0]      addr,
    output logic [DRTB_DATA_W-1:0]      dataIn,
    output logic                        blinkMemorySelect_n
);
    // idle bus: all strobes inactive high
    initial begin
        ce_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        addr = '0;
        dataIn = '0;
        blinkMemorySelect_n = 1'b1;
    end

    // kinds: 0 write, 1 read, 2 shared-strobe write, 3 write that moves the address
    task automatic access(input int kind, input logic [DRTB_ADDR_W-1:0] a, input logic [DRTB_DATA_W-1:0] d,
                          input logic b);
        int n;
        n = 0;
        while (hostReady_r !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        addr = a;
        dataIn = d;
        blinkMemorySelect_n = b;
        @(negedge clk);
        ce_n = 1'b0;
        wr_n = kind != 2;
        rd_n = kind != 1;
        @(negedge clk);
        wr_n = kind == 1;
        if (kind == 3) addr = ~a;                      // breaks address hold on purpose
        @(negedge clk);
        wr_n = 1'b1;
        rd_n = 1'b1;
        ce_n = kind == 2;
        @(negedge clk);
        ce_n = 1'b1;
        addr = ~a;                                     // released lines stop showing old value
        dataIn = ~d;
        // let an edge pass so the next access never reassigns a line in this time step
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

// >>> verification/test_display_refresh_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module test_display_refresh_timebase
    import drtb_pkg::*;
;
    // short counts keep the run brief; expectations follow them
    localparam int OD = 4;
    localparam int FD = 16;
    localparam int SL = 64;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    logic clockSourceSelect = 1'b1;
    logic clkPinIn = 1'b0;
    logic selftestStart = 1'b0;
    logic ce_n, wr_n, rd_n, blinkMemorySelect_n, clkPinOut, clkPinOe, oscTick;
    logic refreshFrequency, blinkPhase_r, blinkFrequency, selftestBusy, selftestDone;
    logic hostReady_r, readActive, writeDone, wrBlinkMem_r, addrUnstable_r;
    logic [2:0] charIndex_r;
    logic [DRTB_ADDR_W-1:0] addr, wrAddr_r, eAddr, aPrev;
    logic [DRTB_DATA_W-1:0] dataIn, wrData_r, eData;
    logic busy, lowPrev, pinPrev, cePrev, unst, low, tk, eBm;
    int tot, refc, blk, st, gap, ph, n, fail_count, checked;
    int seed = 32'h6de7_2623;
    logic [31:0] r, ra;

    drtb_timebase #(.OSC_DIV(OD), .FLASH_DIV(FD), .SELFTEST_LEN(SL)) i_drtb_timebase (
        .clk, .reset_n, .clkEn, .clockSourceSelect, .clkPinIn, .clkPinOut, .clkPinOe,
        .ce_n, .wr_n, .rd_n, .blinkMemorySelect_n, .addr, .dataIn, .selftestStart,
        .oscTick, .charIndex_r, .refreshFrequency, .blinkPhase_r, .blinkFrequency,
        .selftestBusy, .selftestDone, .hostReady_r, .readActive, .writeDone,
        .wrAddr_r, .wrData_r, .wrBlinkMem_r, .addrUnstable_r);
    drtb_host_model i_drtb_host_model (.clk, .hostReady_r, .ce_n, .wr_n, .rd_n, .addr,
        .dataIn, .blinkMemorySelect_n);

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // reference model, compared before each rising edge lands
    // ------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tot = 0;
            refc = 0;
            blk = 0;
            st = 0;
            gap = 0;
            ph = 0;
            busy = 1'b0;
            lowPrev = 1'b0;
            pinPrev = 1'b0;
            cePrev = 1'b1;
            unst = 1'b0;
            eAddr = '0;
            eData = '0;
            eBm = 1'b0;
            aPrev = '0;
        end else begin
            check(clkPinOe, clockSourceSelect);
            check(clkPinOut, ph >= OD / 2);
            check(hostReady_r, tot >= DRTB_LOCKOUT_TICKS);
            check(charIndex_r, refc / DRTB_CHAR_SLOT);
            check(blinkPhase_r, blk >= FD / 2);
            check(selftestBusy, busy);
            check(addrUnstable_r, unst);
            check({wrBlinkMem_r, wrData_r, wrAddr_r}, {eBm, eData, eAddr});
            check(readActive, tot >= DRTB_LOCKOUT_TICKS && !ce_n && !rd_n && wr_n);
            // frozen cycles change nothing, so the model skips them too
            if (clkEn) begin
                low = !ce_n && !wr_n;
                // own oscillator phase count, so the tick is never taken from the design
                tk = clockSourceSelect ? ph == OD / 2 - 1 : clkPinIn && !pinPrev;
                ph = (ph + 1) % OD;
                gap++;
                check(oscTick, tk);
                if (clockSourceSelect && tk) begin
                    if (tot > 0) check(gap, OD);
                    gap = 0;
                end
                check(refreshFrequency, tk && refc == DRTB_REFRESH_DIV - 1);
                check(blinkFrequency, tk && blk == FD - 1);
                check(selftestDone, tk && busy && st == SL - 1);
                check(writeDone, lowPrev && !low && tot >= DRTB_LOCKOUT_TICKS);
                if (busy && tk) begin
                    busy = st != SL - 1;
                    st++;
                end else if (!busy && selftestStart) begin
                    busy = 1'b1;
                    st = 0;
                end
                if (tk) begin
                    tot++;
                    refc = (refc + 1) % DRTB_REFRESH_DIV;
                    blk = (blk + 1) % FD;
                end
                if (!ce_n && !cePrev && addr !== aPrev) unst = 1'b1;
                if (low) begin
                    eAddr = addr;
                    eData = dataIn;
                    eBm = !blinkMemorySelect_n;  // select low targets blink memory
                end
                lowPrev = low;
                pinPrev = clkPinIn;
                cePrev = ce_n;
                aPrev = addr;
            end
        end
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    always #5 clk = ~clk;

    // random freezes; slave pin pulses always keep a low cycle between them
    always @(negedge clk) begin
        r = $random(seed);
        clkEn <= r[1:0] != 2'b00;
        if (!clockSourceSelect) clkPinIn <= !clkPinIn && r[2];
    end

    task automatic hostRun(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            ra = $random(seed);
            i_drtb_host_model.access(i % 4, ra[4:0], ra[12:5], ra[13]);
        end
    endtask

    // master mode, two back-to-back self-tests, then slave mode after a fresh reset
    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        hostRun(40);
        repeat (2) begin
            selftestStart = 1'b1; // held on two cycles into busy to show repeats are ignored
            // frozen cycles may skip the start, so hold it until the test runs
            for (n = 0; n < 50 && !busy; n++) @(negedge clk);
            repeat (2) @(negedge clk);
            selftestStart = 1'b0;
            for (n = 0; n < 3000 && busy; n++) @(negedge clk);
        end
        repeat (1500) @(negedge clk);
        reset_n = 1'b0;
        clockSourceSelect = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        hostRun(20);
        repeat (2000) @(negedge clk);
        results();
    end

    // watchdog well beyond the expected run length
    initial begin
        #200000;
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
